// File: inc/msg_cfg.svh
// Purpose: Constants for the monitor security gate
// Assumes: Bus clock of 25 MHz
// Notes:   Offsets, counts, byte values and serial timing only
`ifndef MSG_CFG_SVH
`define MSG_CFG_SVH
// ==========================================================
// Security locations
`define MSG_SEC_FIRST     16'hFFF6
`define MSG_SEC_LAST      16'hFFFD
`define MSG_SEC_COUNT     4'h8
`define MSG_ERASED_BYTE   8'hFF
`define MSG_INVALID_BYTE  8'h00
// ==========================================================
// Status byte in RAM and its match bit
`define MSG_STATUS_ADDR   16'h0060
`define MSG_STATUS_BIT    6
// ==========================================================
// Serial timing: bus clock and the two monitor rates
`define MSG_CLK_HZ        25000000
`define MSG_BAUD_SLOW     4800
`define MSG_BAUD_FAST     9600
`define MSG_BIT_SLOW      (`MSG_CLK_HZ / `MSG_BAUD_SLOW)
`define MSG_BIT_FAST      (`MSG_CLK_HZ / `MSG_BAUD_FAST)
`define MSG_BREAK_BITS    13
`define MSG_FIFO_DEPTH    8
`endif

// File: inc/msg_pkg.sv
// Purpose: Types for the monitor security gate
// Assumes: Nothing beyond the cfg header
// Notes:   Types only; numbers live in msg_cfg.svh
package msg_pkg;
	// ==========================================================
	// Gate states
	typedef enum logic [2:0] {
		MSG_ST_WAIT  = 3'b000,
		MSG_ST_RECV  = 3'b001,
		MSG_ST_BREAK = 3'b010,
		MSG_ST_DONE  = 3'b011
	} msg_state_t;
	// Flash read request and answer
	typedef struct packed {
		logic        req;
		logic        fetch;
		logic [15:0] addr;
	} msg_flash_req_t;
	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} msg_flash_rsp_t;
endpackage

// File: design/msg_gate.sv
// Purpose: Monitor-mode security gate with serial receive and break send
// Assumes: 8N1 serial on the monitor pin, idle high; one bus clock
// Notes:   Stored bytes arrive on a flat port from nonvolatile memory
`timescale 1ns/100ps
`include "msg_cfg.svh"

// ==========================================================
// Small synchronous FIFO
module msg_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rst_n,
	// Fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_reg;
	logic [AW-1:0]    rd_reg;
	logic [AW:0]      cnt_reg;
	logic             push;
	logic             pop;
	// Honest flags from the fill count
	assign in_ready  = (cnt_reg < (AW+1)'(DEPTH)); // Full at DEPTH words
	assign out_valid = (cnt_reg != '0);
	assign out_data  = mem[rd_reg];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	// Storage has no reset to keep it a plain array
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_reg] <= in_data;
		end
	end
	// Pointers and count
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_reg  <= '0;
			rd_reg  <= '0;
			cnt_reg <= '0;
		end else begin
			if (push) wr_reg <= wr_reg + 1'b1;
			if (pop) rd_reg <= rd_reg + 1'b1;
			cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule // msg_fifo

// What this block does
// RULE1: After power-on into monitor mode, take eight bytes and compare with stored.
// RULE2: All eight equal unlocks flash reads and flash execution.
// RULE3: Unlock lasts until power-on reset; other resets keep it and skip entry.
// RULE4: On mismatch stay in monitor mode but flash reads return an invalid value.
// RULE5: Fetching from flash while locked asks for an illegal-address reset.
// RULE6: Break is sent only after the eighth byte, match or not.
// RULE7: Match sets a readable status bit in RAM; failure leaves it clear.
// RULE8: Host retries only by power-on reset; other resets do not re-arm.
// RULE9: Bulk erase sets all eight stored security bytes to all ones.
// RULE10: User should program the eight locations rather than leave them erased.
// RULE11: Baud select high at reset gives the lower rate, low gives double.
// RULE12: Bytes compare in arrival order with ascending locations; one miss fails all.
// RULE13: Lock decision loads once at eighth byte; cleared only by power-on reset.
module msg_gate #(parameter int BIT_SCALE = 1) ( // Above 1 only shortens bit times
	// Clock and resets
	input  wire logic                 clk,
	input  wire logic                 rst_n,
	input  wire logic                 por_n,
	input  wire logic                 monitor_mode,
	// Monitor serial pin (open drain style)
	input  wire logic                 monitor_serial_pin_in,
	output logic                      monitor_serial_pin_out,
	output logic                      monitor_serial_pin_oe,
	input  wire logic                 baud_select_pin,
	// Stored security bytes, lowest address in the low byte
	input  wire logic [63:0]          stored_bytes,
	input  wire logic                 bulk_erase,
	// Flash access from the core
	input  wire msg_pkg::msg_flash_req_t flash_req,
	input  wire logic [7:0]           flash_rdata,
	output msg_pkg::msg_flash_rsp_t   flash_rsp,
	// Results
	output logic                      unlocked,
	output logic                      illegal_addr_reset,
	output logic [7:0]                status_byte,
	output logic                      gate_ready
);
	// ==========================================================
	// Reset release and pin synchronisers
	logic [1:0] rst_sync;
	logic       srst_n;
	logic [1:0] por_sync;
	logic       spor_n;
	logic [1:0] rx_sync;
	logic [1:0] bsel_sync;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) rst_sync <= 2'b00;
		else rst_sync <= {rst_sync[0], 1'b1};
	end
	assign srst_n = rst_sync[1];
	always_ff @(posedge clk or negedge por_n) begin
		if (!por_n) por_sync <= 2'b00;
		else por_sync <= {por_sync[0], 1'b1};
	end
	assign spor_n = por_sync[1];
	always_ff @(posedge clk or negedge srst_n) begin
		if (!srst_n) rx_sync <= 2'b11;
		else rx_sync <= {rx_sync[0], monitor_serial_pin_in};
	end
	// Strap chain runs through reset, so it is settled when the strap is caught
	always_ff @(posedge clk) begin
		bsel_sync <= {bsel_sync[0], baud_select_pin};
	end

	// ==========================================================
	// Baud select strap caught at reset release
	logic        strap_done_reg;
	logic        slow_reg;
	logic [12:0] bit_len;
	always_ff @(posedge clk or negedge srst_n) begin
		if (!srst_n) begin
			strap_done_reg <= 1'b0;
			slow_reg       <= 1'b1;
		end else if (!strap_done_reg) begin
			strap_done_reg <= 1'b1;
			slow_reg       <= bsel_sync[1]; // [RULE11]
		end
	end
	assign bit_len = slow_reg ? 13'(`MSG_BIT_SLOW / BIT_SCALE) : 13'(`MSG_BIT_FAST / BIT_SCALE); // [RULE11]

	// ==========================================================
	// Serial receiver, 8N1, samples mid bit
	logic [12:0] rx_cnt_reg;
	logic [3:0]  rx_bit_reg;
	logic        rx_busy_reg;
	logic [7:0]  rx_shift_reg;
	logic        rx_valid_reg;
	logic        rx_ready;
	logic        q_valid;
	logic [7:0]  q_data;
	logic        q_take;
	always_ff @(posedge clk or negedge srst_n) begin
		if (!srst_n) begin
			rx_cnt_reg   <= '0;
			rx_bit_reg   <= '0;
			rx_busy_reg  <= 1'b0;
			rx_shift_reg <= '0;
			rx_valid_reg <= 1'b0;
		end else begin
			if (rx_valid_reg && rx_ready) rx_valid_reg <= 1'b0;
			if (!rx_busy_reg) begin
				if (!rx_sync[1]) begin
					rx_busy_reg <= 1'b1;
					rx_cnt_reg  <= bit_len >> 1;
					rx_bit_reg  <= '0;
				end
			end else if (rx_cnt_reg != '0) begin
				rx_cnt_reg <= rx_cnt_reg - 1'b1;
			end else begin
				rx_cnt_reg <= bit_len - 1'b1;
				rx_bit_reg <= rx_bit_reg + 1'b1;
				if (rx_bit_reg == 4'd0 && rx_sync[1]) begin
					rx_busy_reg <= 1'b0; // False start
				end else if (rx_bit_reg >= 4'd1 && rx_bit_reg <= 4'd8) begin
					rx_shift_reg <= {rx_sync[1], rx_shift_reg[7:1]};
				end else if (rx_bit_reg == 4'd9) begin
					rx_busy_reg <= 1'b0;
					// A frame arriving while the FIFO is full shifts over the waiting byte; no second valid is raised
					if (rx_sync[1] && !rx_valid_reg) rx_valid_reg <= 1'b1;
				end
			end
		end
	end

	// Bytes wait here while the comparator is busy
	msg_fifo #(.WIDTH(8), .DEPTH(`MSG_FIFO_DEPTH)) u_fifo (
		.clk       (clk),
		.rst_n     (srst_n),
		.in_valid  (rx_valid_reg),
		.in_ready  (rx_ready),
		.in_data   (rx_shift_reg),
		.out_valid (q_valid),
		.out_ready (q_take),
		.out_data  (q_data)
	);

	// ==========================================================
	// Entry sequence state machine
	msg_pkg::msg_state_t st_reg;
	logic [3:0]  idx_reg;
	logic        miss_reg;
	logic [12:0] brk_cnt_reg;
	logic [3:0]  brk_bits_reg;
	logic [7:0]  stored_now;
	logic [63:0] stored_eff;
	logic        armed_done_reg; // Decision made; cleared by power-on only
	// Erased locations read as all ones
	assign stored_eff = bulk_erase ? {8{`MSG_ERASED_BYTE}} : stored_bytes; // [RULE9]
	assign stored_now = stored_eff[idx_reg[2:0]*8 +: 8]; // [RULE12]
	assign q_take     = (st_reg == msg_pkg::MSG_ST_RECV) && q_valid;
	always_ff @(posedge clk or negedge srst_n) begin
		if (!srst_n) begin
			st_reg       <= msg_pkg::MSG_ST_WAIT;
			idx_reg      <= '0;
			miss_reg     <= 1'b0;
			brk_cnt_reg  <= '0;
			brk_bits_reg <= '0;
		end else begin
			case (st_reg)
				msg_pkg::MSG_ST_WAIT: begin
					// Only a fresh power-on arms the check [RULE1] [RULE3]
					if (monitor_mode && !armed_done_reg && strap_done_reg)
						st_reg <= msg_pkg::MSG_ST_RECV;
					else if (armed_done_reg)
						st_reg <= msg_pkg::MSG_ST_DONE;
				end
				msg_pkg::MSG_ST_RECV: begin
					if (q_valid) begin
						if (q_data != stored_now) miss_reg <= 1'b1; // [RULE12]
						idx_reg <= idx_reg + 1'b1;
						if (idx_reg == `MSG_SEC_COUNT - 4'h1) begin
							st_reg      <= msg_pkg::MSG_ST_BREAK; // [RULE6]
							brk_cnt_reg <= bit_len - 1'b1;
						end
					end
				end
				msg_pkg::MSG_ST_BREAK: begin
					if (brk_cnt_reg != '0) begin
						brk_cnt_reg <= brk_cnt_reg - 1'b1;
					end else begin
						brk_cnt_reg  <= bit_len - 1'b1;
						brk_bits_reg <= brk_bits_reg + 1'b1;
						if (brk_bits_reg == 4'(`MSG_BREAK_BITS - 1))
							st_reg <= msg_pkg::MSG_ST_DONE;
					end
				end
				msg_pkg::MSG_ST_DONE: st_reg <= msg_pkg::MSG_ST_DONE;
				default: st_reg <= msg_pkg::MSG_ST_WAIT;
			endcase
		end
	end

	// ==========================================================
	// Lock decision, held across all but power-on reset
	logic unlock_reg;
	logic last_byte;
	assign last_byte = q_take && (idx_reg == `MSG_SEC_COUNT - 4'h1);
	always_ff @(posedge clk or negedge spor_n) begin
		if (!spor_n) begin
			unlock_reg     <= 1'b0; // [RULE13]
			armed_done_reg <= 1'b0;
		end else if (last_byte && !armed_done_reg) begin
			// Loaded once; a later plain reset cannot rerun it [RULE3] [RULE8] [RULE13]
			unlock_reg     <= !miss_reg && (q_data == stored_now); // [RULE2]
			armed_done_reg <= 1'b1;
		end
	end

	// ==========================================================
	// Outputs: serial drive, flash answer, status
	always_ff @(posedge clk or negedge srst_n) begin
		if (!srst_n) begin
			monitor_serial_pin_out <= 1'b1;
			monitor_serial_pin_oe  <= 1'b0;
			flash_rsp              <= '0;
			unlocked               <= 1'b0;
			illegal_addr_reset     <= 1'b0;
			status_byte            <= '0;
			gate_ready             <= 1'b0;
		end else begin
			// Break holds the line low, driven only in that state [RULE6]
			monitor_serial_pin_out <= (st_reg != msg_pkg::MSG_ST_BREAK);
			monitor_serial_pin_oe  <= (st_reg == msg_pkg::MSG_ST_BREAK);
			flash_rsp.valid        <= flash_req.req && !flash_req.fetch;
			flash_rsp.data         <= unlock_reg ? flash_rdata : `MSG_INVALID_BYTE; // [RULE2] [RULE4]
			illegal_addr_reset     <= flash_req.req && flash_req.fetch && !unlock_reg; // [RULE5]
			unlocked               <= unlock_reg;
			status_byte            <= 8'(unlock_reg) << `MSG_STATUS_BIT; // [RULE7]
			gate_ready             <= (st_reg == msg_pkg::MSG_ST_DONE);
		end
	end

	// ==========================================================
	// Checks
	sequence s_eighth;
		last_byte && !armed_done_reg;
	endsequence
	property p_break_after_eight;
		@(posedge clk) disable iff (!srst_n)
		monitor_serial_pin_oe |-> armed_done_reg;
	endproperty
	a_break_after_eight: assert property (p_break_after_eight) // [RULE6]
		else $error("break sent before eighth byte");
	property p_locked_read;
		@(posedge clk) disable iff (!srst_n)
		(flash_req.req && !flash_req.fetch && !unlock_reg) |=> flash_rsp.data == `MSG_INVALID_BYTE;
	endproperty
	a_locked_read: assert property (p_locked_read) // [RULE4]
		else $error("locked read leaked data");
	property p_locked_fetch;
		@(posedge clk) disable iff (!srst_n)
		(flash_req.req && flash_req.fetch && !unlock_reg) |=> illegal_addr_reset;
	endproperty
	a_locked_fetch: assert property (p_locked_fetch) // [RULE5]
		else $error("locked fetch without reset");
	property p_decision_once;
		@(posedge clk) disable iff (!spor_n)
		armed_done_reg |=> $stable(unlock_reg);
	endproperty
	a_decision_once: assert property (p_decision_once) // [RULE13]
		else $error("lock decision changed");
	property p_status_bit;
		@(posedge clk) disable iff (!srst_n)
		$past(srst_n) |-> status_byte[`MSG_STATUS_BIT] == $past(unlock_reg);
	endproperty
	a_status_bit: assert property (p_status_bit) // [RULE7]
		else $error("status bit wrong");
	property p_break_follows;
		@(posedge clk) disable iff (!srst_n)
		s_eighth |-> ##[1:2] st_reg == msg_pkg::MSG_ST_BREAK;
	endproperty
	a_break_follows: assert property (p_break_follows) // [RULE6]
		else $error("no break after eighth byte");
	property p_miss_locks;
		@(posedge clk) disable iff (!spor_n)
		(s_eighth and miss_reg) |=> !unlock_reg;
	endproperty
	a_miss_locks: assert property (p_miss_locks) // [RULE12]
		else $error("mismatch unlocked");
	property p_unlocked_read;
		@(posedge clk) disable iff (!srst_n)
		(flash_req.req && unlock_reg) |=> flash_rsp.data == $past(flash_rdata);
	endproperty
	a_unlocked_read: assert property (p_unlocked_read) // [RULE2]
		else $error("unlocked read wrong");
endmodule // msg_gate

// File: tb/msg_host_model.sv
// Purpose: Host computer on the far side of the monitor serial pin
// Assumes: 8N1 frames, LSB first; the line idles high through a pull-up
// Notes:   Bit time is handed in per byte, in bus clocks
`timescale 1ns/100ps

// ==========================================================
// Host serial sender
module msg_host_model (
	// Clock
	input  wire logic clk,
	// Host drive; released high between frames
	output logic      host_tx
);
	// Released line reads high, so idle needs no separate pattern
	initial host_tx = 1'b1;

	// One frame: start bit, eight data bits LSB first, stop bit
	task automatic send(input logic [7:0] b, input int bt);
		int i;
		@(posedge clk);
		#1 host_tx = 1'b0;
		repeat (bt) @(posedge clk);
		for (i = 0; i < 8; i++) begin
			#1 host_tx = b[i];
			repeat (bt) @(posedge clk);
		end
		#1 host_tx = 1'b1;
		repeat (bt) @(posedge clk);
	endtask
endmodule // msg_host_model

// File: tb/monitor_security_gate_tb.sv
// Purpose: Self-checking bench for the monitor security gate
// Assumes: Gate at 25 MHz; host frames at both monitor rates
// Notes:   Bit times are divided by SCALE in gate and host alike to keep the run short
`timescale 1ns/100ps
`include "msg_cfg.svh"

// ==========================================================
// Bench top
module monitor_security_gate_tb;
	// Gate inputs
	logic                    clk, rst_n, por_n, monitor_mode, baud_select_pin, bulk_erase;
	logic [63:0]             stored_bytes;
	logic [7:0]              flash_rdata;
	msg_pkg::msg_flash_req_t flash_req;
	// Gate outputs and the shared line
	logic                    pin_out, pin_oe, unlocked, illegal_addr_reset, gate_ready;
	logic                    host_tx, line;
	logic [7:0]              status_byte;
	msg_pkg::msg_flash_rsp_t flash_rsp;
	// Bookkeeping
	int                      err_count, checks_done, sent, brk_cycles;
	localparam int           SCALE = 64; // Bit-time divisor shared by gate and host

	// Open-drain line: low if either party pulls it down
	assign line = host_tx & ~(pin_oe & ~pin_out);

	msg_gate #(.BIT_SCALE(SCALE)) i_msg_gate (.clk(clk), .rst_n(rst_n), .por_n(por_n),
		.monitor_mode(monitor_mode),
		.monitor_serial_pin_in(line), .monitor_serial_pin_out(pin_out),
		.monitor_serial_pin_oe(pin_oe), .baud_select_pin(baud_select_pin),
		.stored_bytes(stored_bytes), .bulk_erase(bulk_erase), .flash_req(flash_req),
		.flash_rdata(flash_rdata), .flash_rsp(flash_rsp), .unlocked(unlocked),
		.illegal_addr_reset(illegal_addr_reset), .status_byte(status_byte),
		.gate_ready(gate_ready));
	msg_host_model i_msg_host_model (.clk(clk), .host_tx(host_tx));

	// ==========================================================
	// Reporting
	task automatic check(input bit ok, input string m);
		checks_done++;
		if (!ok) begin
			err_count++;
			$display("[ERR] %0t %s", $time, m);
		end
	endtask

	task automatic give_verdict();
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// ==========================================================
	// Clock and break watch; a break counts only once all eight bytes began
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	always @(posedge clk) begin
		if (pin_oe === 1'b1 && pin_out === 1'b0) begin
			brk_cycles++;
			if (sent < 8) check(1'b0, "break before eighth byte");
		end
	end

	// Whole run bound, well above two full entries
	initial begin
		repeat (60000) @(posedge clk);
		check(1'b0, "run timeout");
		give_verdict();
	end

	// ==========================================================
	// Helpers
	task automatic do_reset(input bit por);
		@(posedge clk);
		#1 rst_n = 1'b0;
		por_n = ~por;
		repeat (8) @(posedge clk);
		#1 rst_n = 1'b1;
		por_n = 1'b1;
		repeat (4) @(posedge clk);
		#1;
	endtask

	task automatic wait_ready(input int lim);
		int n;
		n = 0;
		while (gate_ready !== 1'b1) begin
			if (n++ >= lim) begin
				check(1'b0, "gate_ready timeout");
				give_verdict();
			end
			@(posedge clk);
			#1;
		end
	endtask

	// Eight frames, then the break must last thirteen bit times
	task automatic entry(input int bt, input logic [63:0] tx);
		int k, b0, d;
		b0 = brk_cycles;
		sent = 0;
		for (k = 0; k < 8; k++) begin
			sent++;
			i_msg_host_model.send(tx[8*k +: 8], bt);
		end
		wait_ready(16 * bt);
		d = brk_cycles - b0 - 13 * bt;
		check(d >= -2 && d <= 2, "break length");
	endtask

	// One-cycle flash request; answer looked at the cycle after
	task automatic flash_op(input logic f, input logic [7:0] rd, input logic [7:0] exp,
		input logic ill);
		@(posedge clk);
		#1 flash_req = '{req: 1'b1, fetch: f, addr: {1'b1, 15'($urandom)}};
		flash_rdata = rd;
		@(posedge clk);
		#1 flash_req.req = 1'b0;
		if (!f) check(flash_rsp.valid === 1'b1 && flash_rsp.data === exp, "flash read data");
		check(illegal_addr_reset === ill, "illegal address reset");
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		logic [63:0] tx;
		int          k;
		rst_n = 1'b0;
		por_n = 1'b0;
		monitor_mode = 1'b1;
		baud_select_pin = 1'b0;
		bulk_erase = 1'b0;
		flash_req = '0;
		flash_rdata = 8'h00;
		stored_bytes = 64'h0;
		sent = 0;
		brk_cycles = 0;
		err_count = 0;
		checks_done = 0;
		k = $urandom(32'h75a3efe1);
		// Locked entry at the fast rate, one random byte spoiled
		stored_bytes = {$urandom, $urandom};
		do_reset(1'b1);
		check(unlocked === 1'b0 && gate_ready === 1'b0 && pin_oe === 1'b0, "after power-on");
		k = $urandom_range(6); // Miss before the last byte, so the early-miss path runs
		tx = stored_bytes ^ (64'(8'($urandom_range(255, 1))) << (8 * k));
		entry(`MSG_BIT_FAST / SCALE, tx);
		check(unlocked === 1'b0, "single miss must lock");
		check(status_byte[`MSG_STATUS_BIT] === 1'b0, "status on failure");
		flash_op(1'b0, 8'($urandom_range(255, 1)), `MSG_INVALID_BYTE, 1'b0);
		flash_op(1'b1, 8'($urandom), 8'h00, 1'b1);
		// Plain reset must neither rerun entry nor unlock
		do_reset(1'b0);
		wait_ready(20);
		check(unlocked === 1'b0, "plain reset re-armed");
		// Retry by power-on at the slow rate; erased store matches all ones
		baud_select_pin = 1'b1;
		bulk_erase = 1'b1;
		do_reset(1'b1);
		check(unlocked === 1'b0 && gate_ready === 1'b0, "power-on re-arm");
		entry(`MSG_BIT_SLOW / SCALE, {8{`MSG_ERASED_BYTE}});
		check(unlocked === 1'b1, "match must unlock");
		check(status_byte[`MSG_STATUS_BIT] === 1'b1, "status on match");
		tx[7:0] = 8'($urandom);
		flash_op(1'b0, tx[7:0], tx[7:0], 1'b0);
		flash_op(1'b1, 8'($urandom), 8'h00, 1'b0);
		// Plain reset keeps the unlock and sends no new break
		k = brk_cycles;
		do_reset(1'b0);
		wait_ready(20);
		repeat (200) @(posedge clk);
		#1;
		check(unlocked === 1'b1 && brk_cycles == k, "unlock after plain reset");
		give_verdict();
	end
endmodule // monitor_security_gate_tb
